// >>> tsl_consts.vh
// constants for the tracker sleep and indicator block
// assumes a 100 MHz pclk and one-word APB register slots
`ifndef TSL_CONSTS_VH
`define TSL_CONSTS_VH
// register byte offsets
`define TSL_OFF_CTRL 12'h000
`define TSL_OFF_TIMEOUT 12'h004
`define TSL_OFF_STATUS 12'h008
`define TSL_OFF_EVENT 12'h00c
// control fields
`define TSL_CTRL_SLEEP_EN 0
`define TSL_CTRL_DEEP_EN 1
`define TSL_CTRL_IGN_SEL 3:2
`define TSL_CTRL_GPS_OFF 4
`define TSL_CTRL_BOOT 5
`define TSL_CTRL_FLASH 6
`define TSL_CTRL_DISABLE 7
`define TSL_CTRL_REC_METH 11:8
`define TSL_CTRL_W 12
`define TSL_CTRL_RST 12'h001
// sleep timeout in seconds
`define TSL_TIMEOUT_RST 16'h003c
// tick rates: 100 MHz clock, 1 ms tick
`define TSL_CLK_HZ 100000000
// cycles per ms at that clock; the count needs 17 bits
`define TSL_MS_W 17
`define TSL_MS_CYCLES 17'd100000
`define TSL_MS_PER_S 16'd1000
// blink half periods and modem burst length in ms
`define TSL_HALF_1S 16'd500
`define TSL_HALF_2S 16'd1000
`define TSL_HALF_FAST 16'd50
`define TSL_BURST_MS 16'd400
// power states
`define TSL_ST_RUN 2'd0
`define TSL_ST_SLEEP 2'd1
`define TSL_ST_DEEP 2'd2
`endif

// >>> tsl_sync.v
// three-stage synchroniser for one asynchronous pin
// assumes pin changes are slow against pclk
`timescale 1ns/100ps
module tsl_sync (
   pclk,
   presetn,
   pin,
   level
);
   input wire pclk;
   input wire presetn;
   input wire pin;
   output reg level;
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   // only s2 reads s1; change accepted when s2 and s3 agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level <= 1'b0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level <= s3_reg;
         end
      end
   end
endmodule // tsl_sync

// >>> tsl_top.v
// sleep sequencing and indicator LEDs of the tracking unit
// assumes an APB master on pclk and raw pins from receiver, sensor, ignition, usb
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "tsl_consts.vh"
module tsl_top (
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   gps_fix,
   gps_time_sync,
   motion,
   din1,
   din2,
   din3,
   usb_detect,
   modem_act,
   trig_time,
   trig_dist,
   trig_angle,
   trig_speed,
   event_in,
   nav_led,
   stat_led,
   gps_power,
   rec_periodic,
   rec_event,
   rec_last_coord,
   asleep
);
   input wire pclk;
   input wire presetn;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [11:0] paddr;
   input wire [31:0] pwdata;
   output reg [31:0] prdata;
   output reg pready;
   output reg pslverr;
   input wire gps_fix;
   input wire gps_time_sync;
   input wire motion;
   input wire din1;
   input wire din2;
   input wire din3;
   input wire usb_detect;
   input wire modem_act;
   input wire trig_time;
   input wire trig_dist;
   input wire trig_angle;
   input wire trig_speed;
   input wire event_in;
   output reg nav_led;
   output reg stat_led;
   output reg gps_power;
   output reg rec_periodic;
   output reg rec_event;
   output reg rec_last_coord;
   output reg asleep;

   wire fix_s, tsync_s, motion_s, din1_s, din2_s, din3_s, usb_s, modem_s;
   wire ttime_s, tdist_s, tang_s, tspd_s, event_s;
   reg [`TSL_CTRL_W-1:0] ctrl_reg;
   reg [15:0] timeout_reg;
   parameter [`TSL_MS_W-1:0] MS_CYCLES = `TSL_MS_CYCLES; // benches shorten it to reach seconds quickly
   reg [`TSL_MS_W-1:0] ms_div_reg;
   reg tick_ms_reg;
   reg [15:0] ms_in_s_reg;
   reg [15:0] idle_s_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [15:0] nav_cnt_reg;
   reg nav_ph_reg;
   reg [15:0] st_cnt_reg;
   reg st_ph_reg;
   reg [15:0] fast_cnt_reg;
   reg fast_ph_reg;
   reg [15:0] burst_reg;
   reg modem_d_reg;
   reg [3:0] evt_sticky_reg;
   reg ign_on;
   reg conds_ok;
   reg wake;
   reg [15:0] st_half;

   // every asynchronous input passes the three-stage filter
   tsl_sync u_fix (.pclk(pclk), .presetn(presetn), .pin(gps_fix), .level(fix_s));
   tsl_sync u_tsy (.pclk(pclk), .presetn(presetn), .pin(gps_time_sync), .level(tsync_s));
   tsl_sync u_mot (.pclk(pclk), .presetn(presetn), .pin(motion), .level(motion_s));
   tsl_sync u_d1 (.pclk(pclk), .presetn(presetn), .pin(din1), .level(din1_s));
   tsl_sync u_d2 (.pclk(pclk), .presetn(presetn), .pin(din2), .level(din2_s));
   tsl_sync u_d3 (.pclk(pclk), .presetn(presetn), .pin(din3), .level(din3_s));
   tsl_sync u_usb (.pclk(pclk), .presetn(presetn), .pin(usb_detect), .level(usb_s));
   tsl_sync u_mdm (.pclk(pclk), .presetn(presetn), .pin(modem_act), .level(modem_s));
   tsl_sync u_tt (.pclk(pclk), .presetn(presetn), .pin(trig_time), .level(ttime_s));
   tsl_sync u_td (.pclk(pclk), .presetn(presetn), .pin(trig_dist), .level(tdist_s));
   tsl_sync u_ta (.pclk(pclk), .presetn(presetn), .pin(trig_angle), .level(tang_s));
   tsl_sync u_ts (.pclk(pclk), .presetn(presetn), .pin(trig_speed), .level(tspd_s));
   tsl_sync u_ev (.pclk(pclk), .presetn(presetn), .pin(event_in), .level(event_s));

   // half-period toggler shared by all blink generators
   function [16:0] blink_step;
      input [15:0] cnt;
      input ph;
      input [15:0] half;
      begin
         if (cnt >= half - 16'd1) begin
            blink_step = {~ph, 16'h0000};
         end else begin
            blink_step = {ph, cnt + 16'd1};
         end
      end
   endfunction

   wire apb_wr = psel && penable && pwrite;
   wire apb_acc = psel && penable;

   // apb slave: zero wait, pready only in access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `TSL_CTRL_RST;
         timeout_reg <= `TSL_TIMEOUT_RST;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               `TSL_OFF_CTRL: prdata <= {20'h00000, ctrl_reg};
               `TSL_OFF_TIMEOUT: prdata <= {16'h0000, timeout_reg};
               `TSL_OFF_STATUS: prdata <= {22'h000000, din3_s, din2_s, usb_s, motion_s,
                                           tsync_s, fix_s, din1_s, asleep, state_reg};
               `TSL_OFF_EVENT: prdata <= {28'h0000000, evt_sticky_reg};
               default: begin
                  prdata <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (apb_wr && pready) begin
            case (paddr)
               `TSL_OFF_CTRL: ctrl_reg <= pwdata[`TSL_CTRL_W-1:0];
               `TSL_OFF_TIMEOUT: timeout_reg <= pwdata[15:0];
               default: ctrl_reg <= ctrl_reg;
            endcase
         end
      end
   end

   // 1 ms tick; seconds are counted in the stationary counter below
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_div_reg <= {`TSL_MS_W{1'b0}};
         tick_ms_reg <= 1'b0;
      end else if (ms_div_reg == MS_CYCLES - 1'b1) begin
         ms_div_reg <= {`TSL_MS_W{1'b0}};
         tick_ms_reg <= 1'b1;
      end else begin
         ms_div_reg <= ms_div_reg + 1'b1;
         tick_ms_reg <= 1'b0;
      end
   end

   // ignition source select; code 0 is din1, the dedicated ignition pin
   always @* begin
      case (ctrl_reg[`TSL_CTRL_IGN_SEL])
         2'd0: ign_on = din1_s;
         2'd1: ign_on = din2_s;
         2'd2: ign_on = din3_s;
         default: ign_on = motion_s;
      endcase
   end

   // entry and exit conditions
   always @* begin
      conds_ok = (ctrl_reg[`TSL_CTRL_SLEEP_EN] || ctrl_reg[`TSL_CTRL_DEEP_EN]) && tsync_s &&
                 !motion_s && !ign_on && !usb_s;
      wake = motion_s || ign_on || usb_s;
   end

   // stationary seconds counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_in_s_reg <= 16'h0000;
         idle_s_reg <= 16'h0000;
      end else if (motion_s || ign_on) begin
         ms_in_s_reg <= 16'h0000;
         idle_s_reg <= 16'h0000;
      end else if (tick_ms_reg) begin
         if (ms_in_s_reg == `TSL_MS_PER_S - 16'd1) begin
            ms_in_s_reg <= 16'h0000;
            if (idle_s_reg != 16'hffff) begin
               idle_s_reg <= idle_s_reg + 16'd1;
            end
         end else begin
            ms_in_s_reg <= ms_in_s_reg + 16'd1;
         end
      end
   end

   // power state machine; deep sleep wins when both are enabled
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `TSL_ST_RUN: begin
            if (conds_ok && idle_s_reg >= timeout_reg) begin
               state_next = ctrl_reg[`TSL_CTRL_DEEP_EN] ? `TSL_ST_DEEP : `TSL_ST_SLEEP;
            end
         end
         `TSL_ST_SLEEP, `TSL_ST_DEEP: begin
            if (wake) begin
               state_next = `TSL_ST_RUN;
            end
         end
         default: state_next = `TSL_ST_RUN;
      endcase
   end

   // state register and record outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= `TSL_ST_RUN;
         asleep <= 1'b0;
         gps_power <= 1'b1;
         rec_periodic <= 1'b0;
         rec_event <= 1'b0;
         rec_last_coord <= 1'b0;
         evt_sticky_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         asleep <= (state_next != `TSL_ST_RUN);
         gps_power <= (state_next == `TSL_ST_RUN) && !ctrl_reg[`TSL_CTRL_GPS_OFF];
         rec_periodic <= (state_next == `TSL_ST_RUN) &&
                         |(ctrl_reg[`TSL_CTRL_REC_METH] & {tspd_s, tang_s, tdist_s, ttime_s});
         rec_event <= event_s;
         rec_last_coord <= (state_next != `TSL_ST_RUN) || !fix_s;
         // set wins over write-one clear
         evt_sticky_reg <= (evt_sticky_reg & ~((apb_wr && pready && paddr == `TSL_OFF_EVENT) ?
                           pwdata[3:0] : 4'h0)) | {tspd_s, tang_s, tdist_s, ttime_s};
      end
   end

   // blink timebases
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nav_cnt_reg <= 16'h0000;
         nav_ph_reg <= 1'b0;
         st_cnt_reg <= 16'h0000;
         st_ph_reg <= 1'b0;
         fast_cnt_reg <= 16'h0000;
         fast_ph_reg <= 1'b0;
      end else if (tick_ms_reg) begin
         {nav_ph_reg, nav_cnt_reg} <= blink_step(nav_cnt_reg, nav_ph_reg, `TSL_HALF_1S);
         {st_ph_reg, st_cnt_reg} <= blink_step(st_cnt_reg, st_ph_reg, st_half);
         {fast_ph_reg, fast_cnt_reg} <= blink_step(fast_cnt_reg, fast_ph_reg, `TSL_HALF_FAST);
      end
   end

   always @* begin
      st_half = (state_reg == `TSL_ST_DEEP) ? `TSL_HALF_2S : `TSL_HALF_1S;
   end

   // modem burst timer, retriggered on each rising activity edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_d_reg <= 1'b0;
         burst_reg <= 16'h0000;
      end else begin
         modem_d_reg <= modem_s;
         if (modem_s && !modem_d_reg) begin
            burst_reg <= `TSL_BURST_MS;
         end else if (tick_ms_reg && burst_reg != 16'h0000) begin
            burst_reg <= burst_reg - 16'd1;
         end
      end
   end

   // led drivers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nav_led <= 1'b0;
         stat_led <= 1'b0;
      end else begin
         if (!gps_power || state_reg == `TSL_ST_DEEP) begin
            nav_led <= 1'b0;
         end else if (!fix_s) begin
            nav_led <= 1'b1;
         end else begin
            nav_led <= nav_ph_reg;
         end
         if (ctrl_reg[`TSL_CTRL_DISABLE] || ctrl_reg[`TSL_CTRL_FLASH]) begin
            stat_led <= 1'b0;
         end else if (ctrl_reg[`TSL_CTRL_BOOT]) begin
            stat_led <= fast_ph_reg;
         end else if (burst_reg != 16'h0000) begin
            stat_led <= fast_ph_reg;
         end else begin
            stat_led <= st_ph_reg;
         end
      end
   end
endmodule // tsl_top

// >>> tsl_properties.sv
// concurrent checks on the sleep and indicator block
// assumes binding onto tsl_top, every check sampled on pclk
`timescale 1ns/100ps
module tsl_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire gps_fix,
   input wire gps_time_sync,
   input wire motion,
   input wire usb_detect,
   input wire nav_led,
   input wire gps_power,
   input wire rec_periodic,
   input wire rec_last_coord,
   input wire asleep
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // one wait-free access cycle after every setup
   a_apb_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready is not a single access pulse");
   // pin inputs pass a filter, so look a few cycles back
   a_sleep_entry_ok: assert property ($rose(asleep) |-> $past(gps_time_sync, 3) && !$past(usb_detect, 3))
      else $error("sleep entered without time sync or with usb attached");
   a_wake_on_usb: assert property ($rose(usb_detect) && asleep |-> ##[1:12] !asleep)
      else $error("usb attach did not end sleep");
   a_wake_on_motion: assert property ($rose(motion) && asleep |-> ##[1:12] !asleep)
      else $error("motion did not end sleep");
   a_sleep_gps_down: assert property (asleep[*3] |-> !gps_power)
      else $error("gps powered while asleep");
   a_sleep_no_periodic: assert property (asleep[*3] |-> !rec_periodic)
      else $error("periodic record while asleep");
   a_nav_lit_nofix: assert property ((gps_power && !asleep && !gps_fix)[*8] |-> nav_led)
      else $error("navigation led dark without gps signal");
   a_nav_dark_off: assert property (!gps_power[*4] |-> !nav_led)
      else $error("navigation led lit with gps powered down");
   a_fix_lost_coord: assert property (!gps_fix[*8] |-> rec_last_coord)
      else $error("records without last coordinate after fix loss");
   cover property ($rose(asleep));
   cover property ($fell(asleep));
   cover property (nav_led && !gps_fix);
endmodule // tsl_checker

bind tsl_top tsl_checker tsl_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .gps_fix(gps_fix), .gps_time_sync(gps_time_sync), .motion(motion),
   .usb_detect(usb_detect), .nav_led(nav_led), .gps_power(gps_power), .rec_periodic(rec_periodic),
   .rec_last_coord(rec_last_coord), .asleep(asleep));

// >>> tsl_far_model.sv
// far side: receiver, movement sensor, ignition, usb, modem and trigger pins
// assumes the bench sets want; pins follow just after each rising edge
`timescale 1ns/100ps
module tsl_far_model (
   input wire pclk,
   input wire [12:0] want,
   output logic [12:0] pins = 13'h0000
);
   // registered so pins never move on the sampling edge itself
   always @(posedge pclk) begin
      pins <= want;
   end
endmodule // tsl_far_model

// >>> tsl_top_tb.sv
// self-checking bench for the sleep and indicator block
// assumes tsl_top, tsl_far_model and the bound checker are compiled first
`timescale 1ns/100ps
`include "tsl_consts.vh"
module tsl_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [12:0] want = 13'h0003;
   wire [12:0] pins;
   wire [31:0] prdata;
   wire pready, pslverr, nav_led, stat_led, gps_power, rec_periodic, rec_event, rec_last_coord, asleep;
   int fail_count = 0;
   int checks = 0;
   int k;
   logic [31:0] r;
   logic [32:0] exp_q[$];
   // short ms so that second-scale led patterns and timeouts fit the run
   localparam logic [16:0] MS = 17'h00004;
   always #5 pclk = ~pclk;
   tsl_far_model tsl_far_model_i (.pclk(pclk), .want(want), .pins(pins));
   tsl_top #(.MS_CYCLES(MS)) tsl_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gps_fix(pins[0]), .gps_time_sync(pins[1]), .motion(pins[2]), .din1(pins[3]), .din2(pins[4]),
      .din3(pins[5]), .usb_detect(pins[6]), .modem_act(pins[7]), .trig_time(pins[8]), .trig_dist(pins[9]),
      .trig_angle(pins[10]), .trig_speed(pins[11]), .event_in(pins[12]), .nav_led(nav_led),
      .stat_led(stat_led), .gps_power(gps_power), .rec_periodic(rec_periodic), .rec_event(rec_event),
      .rec_last_coord(rec_last_coord), .asleep(asleep));
   task automatic fail_if(input logic bad, input logic [32:0] got, input logic [32:0] exp);
      checks++;
      if (bad) begin
         fail_count++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
      fail_if(got !== exp, got, exp);
   endtask
   task automatic cmp_lvl(input logic got, input logic exp);
      fail_if(got !== exp, {32'h0, got}, {32'h0, exp});
   endtask
   task automatic cmp_time(input logic [31:0] got, input logic [31:0] exp);
      fail_if(got !== exp, {1'b0, got}, {1'b0, exp});
   endtask
   // cycles between two led toggles; the first toggle only aligns the count
   task automatic led_half(input logic s, input logic [31:0] exp);
      logic [31:0] n;
      logic v;
      n = 0;
      for (int i = 0; i < 2; i++) begin
         n = 0;
         v = s ? stat_led : nav_led;
         while ((s ? stat_led : nav_led) === v && n < 32'h00002000) begin
            @(posedge pclk);
            n++;
         end
      end
      cmp_time(n, exp);
   endtask
   // apb master: hold the request until pready is seen at an edge
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
      exp_q.push_back({err, exp});
      xfer(a, 1'b0, 32'h0);
   endtask
   task automatic put(input int b, input logic v);
      @(posedge pclk);
      want[b] <= v;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task wrap_up;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // read results are judged against the oldest note in the queue
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         cmp_rd({pslverr, prdata}, exp_q.pop_front());
      end
   end
   // hang guard, above the roughly 30000 cycles the tests need
   initial begin
      #400000;
      fail_count++;
      wrap_up();
   end
   initial begin
      r = $urandom(32'h4404);
      wait_n(4);
      cmp_lvl(gps_power, 1'b1);
      cmp_lvl(asleep, 1'b0);
      presetn <= 1'b1;
      rd(`TSL_OFF_CTRL, 32'h001, 1'b0);
      rd(`TSL_OFF_TIMEOUT, 32'h03c, 1'b0);
      rd(12'h010, 32'h0, 1'b1);
      xfer(`TSL_OFF_STATUS, 1'b1, 32'hffffffff);
      rd(`TSL_OFF_STATUS, 32'h030, 1'b0);
      r = $urandom;
      xfer(`TSL_OFF_TIMEOUT, 1'b1, r);
      rd(`TSL_OFF_TIMEOUT, r & 32'hffff, 1'b0);
      $display("test registers done");
      // zero timeout: sleep follows once the conditions hold
      xfer(`TSL_OFF_TIMEOUT, 1'b1, 32'h0);
      wait_n(20);
      cmp_lvl(asleep, 1'b1);
      cmp_lvl(gps_power, 1'b0);
      cmp_lvl(rec_last_coord, 1'b1);
      rd(`TSL_OFF_STATUS, 32'h035, 1'b0);
      put(12, 1'b1);
      wait_n(8);
      cmp_lvl(rec_event, 1'b1);
      put(12, 1'b0);
      // motion, ignition on din1, usb: each alone ends sleep
      for (k = 0; k < 3; k++) begin
         put(k == 0 ? 2 : k == 1 ? 3 : 6, 1'b1);
         wait_n(15);
         cmp_lvl(asleep, 1'b0);
         put(k == 0 ? 2 : k == 1 ? 3 : 6, 1'b0);
         wait_n(20);
         cmp_lvl(asleep, 1'b1);
      end
      // other ignition sources: din1 then no longer wakes
      for (k = 1; k < 4; k++) begin
         xfer(`TSL_OFF_CTRL, 1'b1, 32'h001 | (k << 2));
         put(3, 1'b1);
         wait_n(15);
         cmp_lvl(asleep, 1'b1);
         put(3, 1'b0);
         put(k == 3 ? 2 : 3 + k, 1'b1);
         wait_n(15);
         cmp_lvl(asleep, 1'b0);
         put(k == 3 ? 2 : 3 + k, 1'b0);
      end
      $display("test wake done");
      // missing time sync, usb attached or sleep disabled: each keeps the unit awake
      for (k = 0; k < 3; k++) begin
         xfer(`TSL_OFF_CTRL, 1'b1, k == 2 ? 32'h0 : 32'h1);
         if (k == 0) put(1, 1'b0);
         if (k == 1) put(6, 1'b1);
         put(2, 1'b1);
         wait_n(10);
         put(2, 1'b0);
         wait_n(20);
         cmp_lvl(asleep, 1'b0);
         xfer(`TSL_OFF_CTRL, 1'b1, 32'h1);
         want <= 13'h0003;
         wait_n(20);
         cmp_lvl(asleep, 1'b1);
      end
      $display("test entry done");
      xfer(`TSL_OFF_CTRL, 1'b1, 32'h0);
      // the unit is asleep here; motion wakes it and sleep stays disabled
      put(2, 1'b1);
      wait_n(10);
      put(2, 1'b0);
      put(0, 1'b0);
      wait_n(15);
      cmp_lvl(nav_led, 1'b1);
      cmp_lvl(rec_last_coord, 1'b1);
      xfer(`TSL_OFF_CTRL, 1'b1, 32'h010);
      wait_n(15);
      cmp_lvl(gps_power, 1'b0);
      cmp_lvl(nav_led, 1'b0);
      xfer(`TSL_OFF_CTRL, 1'b1, 32'h080);
      wait_n(10);
      cmp_lvl(stat_led, 1'b0);
      xfer(`TSL_OFF_CTRL, 1'b1, 32'h040);
      wait_n(10);
      cmp_lvl(stat_led, 1'b0);
      $display("test leds done");
      // every record method, sticky event bit cleared by writing one
      xfer(`TSL_OFF_CTRL, 1'b1, 32'hf00);
      for (k = 0; k < 4; k++) begin
         put(8 + k, 1'b1);
         wait_n(10);
         cmp_lvl(rec_periodic, 1'b1);
         put(8 + k, 1'b0);
         wait_n(10);
         cmp_lvl(rec_periodic, 1'b0);
         rd(`TSL_OFF_EVENT, 32'h1 << k, 1'b0);
         xfer(`TSL_OFF_EVENT, 1'b1, 32'h1 << k);
         rd(`TSL_OFF_EVENT, 32'h0, 1'b0);
      end
      $display("test records done");
      // blink patterns, counted in pclk cycles with the short ms
      xfer(`TSL_OFF_CTRL, 1'b1, 32'h000);
      put(0, 1'b1);
      wait_n(10);
      led_half(1'b0, `TSL_HALF_1S * MS);
      led_half(1'b1, `TSL_HALF_1S * MS);
      xfer(`TSL_OFF_CTRL, 1'b1, 32'h020);
      wait_n(10);
      led_half(1'b1, `TSL_HALF_FAST * MS);
      xfer(`TSL_OFF_CTRL, 1'b1, 32'h000);
      put(7, 1'b1);
      wait_n(20);
      led_half(1'b1, `TSL_HALF_FAST * MS);
      put(7, 1'b0);
      wait_n(`TSL_BURST_MS * MS);
      led_half(1'b1, `TSL_HALF_1S * MS);
      // deep sleep: slow status blink, navigation led dark
      xfer(`TSL_OFF_CTRL, 1'b1, 32'h002);
      wait_n(20);
      rd(`TSL_OFF_STATUS, 32'h036, 1'b0);
      cmp_lvl(nav_led, 1'b0);
      led_half(1'b1, `TSL_HALF_2S * MS);
      $display("test blinks done");
      // a one second timeout starts only once motion stops
      xfer(`TSL_OFF_TIMEOUT, 1'b1, 32'h1);
      xfer(`TSL_OFF_CTRL, 1'b1, 32'h001);
      put(2, 1'b1);
      wait_n(10);
      put(2, 1'b0);
      wait_n(`TSL_MS_PER_S * MS * 3 / 4);
      cmp_lvl(asleep, 1'b0);
      wait_n(`TSL_MS_PER_S * MS / 4 + 200);
      cmp_lvl(asleep, 1'b1);
      $display("test timeout done");
      wrap_up();
   end
endmodule // tsl_top_tb
